/* scc_params.svh */
`ifndef SCC_PARAMS_SVH
`define SCC_PARAMS_SVH
// Operation
// - Reset clears every clock configuration bit except phase, which is set.
// - The low-power stop state leaves the clock configuration untouched.
// - Idle master serial clock rests at the polarity bit level.
// - Phase and polarity act only in SPI, never in two-wire mode.
// - Phase with polarity chooses the capture edge and the change edge.
// - Slave, phase 0: holding word loads only while select is high, sets empty.
// - Slave, phase 1: holding word loads once shifter empties, sets empty flag.
// - Master, phase 0: word loads at once, empty flag sets at word end.
// - Master, phase 1: word loads once shifter empties, empty flag sets then.
// - Software writes holding word only when empty flag is set; write clears it.
// - A bypassable divide-by-eight prescaler precedes the clock divider.
// - Eight-bit modulus in bits 10..3 divides by one to 256.
// - Slave mode ignores the divider, except two-wire slave with clock freeze.
// - Bits 23..14 and 11 are reserved and read as zero.
// - Filter mode bits 13..12: bypass, reserved, narrow, wide.
// - Spike filters sit on clock input and on the selected data input.
// - Narrow filter removes spikes up to 50 ns, wide up to 100 ns.
// - Enable bit activates the port; clearing it resets port, keeps configuration.
// - Clock freeze acts in two-wire slave mode, holding clock low when unready.
// - A write to the holding register of an enabled port outside the stop state clears the empty flag unless a set falls in that cycle.

// Byte addresses on the register bus
`define SCC_ADDR_CFG  4'h0
`define SCC_ADDR_CTL  4'h4
`define SCC_ADDR_DATA 4'h8

// Clock configuration fields
`define SCC_CFG_RESET 24'h000001
`define SCC_CFG_WMASK 24'h0037ff
`define SCC_CFG_CPHA  0
`define SCC_CFG_CPOL  1
`define SCC_CFG_BYP   2
`define SCC_CFG_DM    3
`define SCC_CFG_FM    12

// Port control and status fields
`define SCC_CTL_EN    0
`define SCC_CTL_I2C   1
`define SCC_CTL_WSZ   2
`define SCC_CTL_FRZ   4
`define SCC_CTL_MST   6
`define SCC_CTL_TDE   16
`define SCC_CTL_BUSY  22

// Timing
`define SCC_CLK_NS     40
`define SCC_NARROW_NS  50
`define SCC_WIDE_NS    100
// Most core samples that one tolerated spike can cover
`define SCC_NARROW_CYC (`SCC_NARROW_NS / `SCC_CLK_NS + 1)
`define SCC_WIDE_CYC   (`SCC_WIDE_NS / `SCC_CLK_NS + 1)
`define SCC_PRESCALE   8
`endif

/* scc_pkg.sv */
package scc_pkg;

  typedef enum logic {SCC_IDLE, SCC_SHIFT} scc_xfer_t;

  typedef struct packed {
    logic [23:0] cfg;
    logic        en;
    logic        i2c;
    logic [1:0]  wsz;
    logic        frz;
    logic        mst;
    scc_xfer_t   xs;
    logic [23:0] hold;
    logic        hfull;
    logic        tde;
    logic [23:0] tx;
    logic [23:0] rx;
    logic [23:0] rxw;
    logic [5:0]  ec;
    logic        sck;
    logic        sck_oe;
    logic        mosi_oe;
    logic        miso_oe;
    logic        sckf;
    logic [1:0]  ss_s;
    logic [1:0]  sck_s;
    logic [1:0]  mosi_s;
    logic [1:0]  miso_s;
    logic        ack;
    logic        wreq;
    logic [31:0] rdata;
  } scc_top_st_t;

  typedef struct packed {
    logic [2:0] pre;
    logic [7:0] div;
    logic       tick;
  } scc_div_st_t;

  typedef struct packed {
    logic       out;
    logic [3:0] cnt;
  } scc_flt_st_t;

  function automatic logic [4:0] scc_word_bits(input logic [1:0] wsz);
    case (wsz)
      2'h0:    scc_word_bits = 5'h08;
      2'h1:    scc_word_bits = 5'h10;
      default: scc_word_bits = 5'h18;
    endcase
  endfunction

endpackage

/* scc_clkdiv.sv */
`timescale 1ns/1ps
`include "scc_params.svh"
module scc_clkdiv #(
  parameter int PRESCALE = `SCC_PRESCALE
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic       run_i,
  input  wire logic       bypass_i,
  input  wire logic [7:0] modulus_i,
  output logic            tick_o
);
  scc_pkg::scc_div_st_t st_q;
  scc_pkg::scc_div_st_t st_d;
  logic                 pre_end;

  assign pre_end = bypass_i | (st_q.pre == 3'(PRESCALE - 1));

  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (!run_i || !rstn_i) begin
      st_d = '0;
    end else begin
      st_d.pre = pre_end ? 3'h0 : st_q.pre + 3'h1;
      if (pre_end) begin
        // Zero modulus with bypass ticks every cycle; software must avoid it
        if (st_q.div == modulus_i) begin
          st_d.div  = 8'h00;
          st_d.tick = 1'b1;
        end else begin
          st_d.div = st_q.div + 8'h01;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st_q <= st_d;
  end

  assign tick_o = st_q.tick;

  // Helper: cycles since the previous tick
  logic [11:0] gap_q;
  logic        seen_q;
  always_ff @(posedge sys_clk_i) begin
    if (!rstn_i || !run_i) begin
      gap_q  <= 12'h000;
      seen_q <= 1'b0;
    end else begin
      gap_q  <= st_q.tick ? 12'h001 : gap_q + 12'h001;
      seen_q <= seen_q | st_q.tick;
    end
  end

  a_div_gap: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (st_q.tick && seen_q && run_i && $stable(modulus_i) && $stable(bypass_i))
    |-> gap_q == (bypass_i ? 12'h001 : 12'(PRESCALE)) * (12'h001 + 12'(modulus_i)))
    else $error("divider tick spacing wrong");
endmodule

/* scc_spike_filter.sv */
`timescale 1ns/1ps
`include "scc_params.svh"
module scc_spike_filter #(
  parameter int NARROW_CYC = `SCC_NARROW_CYC,
  parameter int WIDE_CYC   = `SCC_WIDE_CYC
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rstn_i,
  input  wire logic [1:0] mode_i,
  input  wire logic       in_i,
  output logic            out_o
);
  scc_pkg::scc_flt_st_t st_q;
  scc_pkg::scc_flt_st_t st_d;
  logic [3:0]           lim;

  // Reserved mode 01 behaves as bypass; a new level must outlast the
  // longest spike by one sample, at the cost of that much input delay
  assign lim = (mode_i == 2'h3) ? 4'(WIDE_CYC) : 4'(NARROW_CYC);

  always_comb begin
    st_d = st_q;
    if (!mode_i[1]) begin
      st_d.out = in_i;
      st_d.cnt = 4'h0;
    end else if (in_i == st_q.out) begin
      st_d.cnt = 4'h0;
    end else if (st_q.cnt == lim) begin
      st_d.out = in_i;
      st_d.cnt = 4'h0;
    end else begin
      st_d.cnt = st_q.cnt + 4'h1;
    end
    if (!rstn_i) begin
      st_d = '0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st_q <= st_d;
  end

  assign out_o = st_q.out;

  a_flt_wide: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (mode_i == 2'h3 && $past(mode_i, 4) == 2'h3 && $changed(st_q.out))
    |-> ($past(in_i, 1) == st_q.out && $past(in_i, 2) == st_q.out
         && $past(in_i, 3) == st_q.out && $past(in_i, 4) == st_q.out))
    else $error("wide filter passed a short spike");

  a_flt_bypass: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (mode_i == 2'h0) |=> st_q.out == $past(in_i))
    else $error("bypass filter did not follow input");
endmodule

/* scc_top.sv */
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "scc_params.svh"
module scc_top (
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  input  wire logic        stop_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        ss_n_i,
  input  wire logic        sck_i,
  output logic             sck_o,
  output logic             sck_oe_o,
  input  wire logic        mosi_i,
  output logic             mosi_o,
  output logic             mosi_oe_o,
  input  wire logic        miso_i,
  output logic             miso_o,
  output logic             miso_oe_o
);
  scc_pkg::scc_top_st_t st_q;
  scc_pkg::scc_top_st_t st_d;

  logic       act;
  logic       spi;
  logic       cpha;
  logic       cpol;
  logic       m0;
  logic       ss_hi;
  logic       tick;
  logic       sck_f;
  logic       din_f;
  logic       edge_ev;
  logic       sample;
  logic       done;
  logic       load;
  logic       set_tde;
  logic       we_cfg;
  logic       we_ctl;
  logic       we_tx;
  logic [4:0] nb;
  logic [5:0] last_ec;

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  assign act   = st_q.en & ~stop_i;
  assign spi   = ~st_q.i2c;
  assign cpha  = st_q.cfg[`SCC_CFG_CPHA];
  assign cpol  = st_q.cfg[`SCC_CFG_CPOL];
  assign m0    = st_q.mst & ~cpha;
  assign ss_hi = st_q.ss_s[1];
  assign nb    = scc_pkg::scc_word_bits(st_q.wsz);
  assign last_ec = {nb, 1'b0} - 6'h01;

  // ---------------------------------------------------------------
  // Clock generator and input filters
  // ---------------------------------------------------------------
  scc_clkdiv #(
    .PRESCALE (`SCC_PRESCALE)
  ) u_div (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .run_i     (act & (st_q.mst | (st_q.i2c & st_q.frz))),
    .bypass_i  (st_q.cfg[`SCC_CFG_BYP]),
    .modulus_i (st_q.cfg[`SCC_CFG_DM +: 8]),
    .tick_o    (tick)
  );

  scc_spike_filter #(
    .NARROW_CYC (`SCC_NARROW_CYC),
    .WIDE_CYC   (`SCC_WIDE_CYC)
  ) u_flt_sck (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .mode_i    (st_q.cfg[`SCC_CFG_FM +: 2]),
    .in_i      (st_q.sck_s[1]),
    .out_o     (sck_f)
  );

  // Data line: master-in as SPI master, master-out (or two-wire data) otherwise
  scc_spike_filter #(
    .NARROW_CYC (`SCC_NARROW_CYC),
    .WIDE_CYC   (`SCC_WIDE_CYC)
  ) u_flt_dat (
    .sys_clk_i (sys_clk_i),
    .rstn_i    (rstn_i),
    .mode_i    (st_q.cfg[`SCC_CFG_FM +: 2]),
    .in_i      ((st_q.mst & spi) ? st_q.miso_s[1] : st_q.mosi_s[1]),
    .out_o     (din_f)
  );

  // ---------------------------------------------------------------
  // Shift engine events
  // ---------------------------------------------------------------
  // Master edges come from the divider; slave edges from the filtered clock
  assign edge_ev = act & spi & (st_q.mst ? (tick & (st_q.xs == scc_pkg::SCC_SHIFT))
                                         : ((sck_f != st_q.sckf) & ~ss_hi));
  assign sample  = cpha ? st_q.ec[0] : ~st_q.ec[0];
  assign done    = edge_ev & (st_q.ec == last_ec);
  // Slave phase 0 waits for select high; other cases load once shifter empty
  assign load    = act & spi & st_q.hfull & (st_q.xs == scc_pkg::SCC_IDLE) & ~edge_ev
                   & (st_q.ec == 6'h00) & (st_q.mst | cpha | ss_hi);
  assign set_tde = (load & ~m0) | (done & m0);

  assign we_cfg = avs_write_i & st_q.ack & (avs_address_i == `SCC_ADDR_CFG);
  assign we_ctl = avs_write_i & st_q.ack & (avs_address_i == `SCC_ADDR_CTL);
  assign we_tx  = avs_write_i & st_q.ack & (avs_address_i == `SCC_ADDR_DATA);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d        = st_q;
    st_d.ss_s   = {st_q.ss_s[0], ss_n_i};
    st_d.sck_s  = {st_q.sck_s[0], sck_i};
    st_d.mosi_s = {st_q.mosi_s[0], mosi_i};
    st_d.miso_s = {st_q.miso_s[0], miso_i};
    st_d.sckf   = sck_f;

    // Bus slave: one wait cycle, then a single-cycle answer
    st_d.ack  = (avs_read_i | avs_write_i) & ~st_q.ack;
    st_d.wreq = ~st_d.ack;
    if (avs_read_i && !st_q.ack) begin
      st_d.rdata = 32'h0000_0000;
      case (avs_address_i)
        `SCC_ADDR_CFG: begin
          st_d.rdata[23:0] = st_q.cfg;
        end
        `SCC_ADDR_CTL: begin
          st_d.rdata[`SCC_CTL_EN]        = st_q.en;
          st_d.rdata[`SCC_CTL_I2C]       = st_q.i2c;
          st_d.rdata[`SCC_CTL_WSZ +: 2]  = st_q.wsz;
          st_d.rdata[`SCC_CTL_FRZ]       = st_q.frz;
          st_d.rdata[`SCC_CTL_MST]       = st_q.mst;
          st_d.rdata[`SCC_CTL_TDE]       = st_q.tde;
          st_d.rdata[`SCC_CTL_BUSY]      = (st_q.xs == scc_pkg::SCC_SHIFT);
        end
        `SCC_ADDR_DATA: begin
          st_d.rdata[23:0] = st_q.rxw;
        end
        default: begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Configuration survives stop and disable; only a write or reset changes it
    if (we_cfg) begin
      st_d.cfg = avs_writedata_i[23:0] & `SCC_CFG_WMASK;
    end
    if (we_ctl) begin
      st_d.en  = avs_writedata_i[`SCC_CTL_EN];
      st_d.i2c = avs_writedata_i[`SCC_CTL_I2C];
      st_d.wsz = avs_writedata_i[`SCC_CTL_WSZ +: 2];
      st_d.frz = avs_writedata_i[`SCC_CTL_FRZ];
      st_d.mst = avs_writedata_i[`SCC_CTL_MST];
    end

    // Serial shifting, MSB first
    if (edge_ev) begin
      st_d.ec = st_q.ec + 6'h01;
      if (sample) begin
        st_d.rx = {st_q.rx[22:0], din_f};
      end else if (st_q.ec != 6'h00) begin
        st_d.tx = {st_q.tx[22:0], 1'b0};
      end
    end
    if (done) begin
      st_d.xs  = scc_pkg::SCC_IDLE;
      st_d.ec  = 6'h00;
      st_d.rxw = st_d.rx << (5'h18 - nb);
    end
    // Deselect between words aborts a partial slave word
    if (!st_q.mst && ss_hi) begin
      st_d.ec = 6'h00;
    end
    if (load) begin
      st_d.tx    = st_q.hold;
      st_d.xs    = scc_pkg::SCC_SHIFT;
      st_d.hfull = 1'b0;
    end
    if (we_tx) begin
      st_d.hold  = avs_writedata_i[23:0];
      st_d.hfull = 1'b1;
      st_d.tde   = 1'b0;
    end
    // A set in the same cycle as the clearing write wins
    if (set_tde) begin
      st_d.tde = 1'b1;
    end

    // SPI master clock rests at polarity level between words; the two-wire clock stays low
    if (st_q.i2c) begin
      st_d.sck = 1'b0;
    end else if (st_q.xs == scc_pkg::SCC_SHIFT && st_q.mst) begin
      st_d.sck = tick ? ~st_q.sck : st_q.sck;
    end else begin
      st_d.sck = cpol;
    end
    if (done) begin
      st_d.sck = cpol;
    end

    // Freeze pulls the two-wire clock low while nothing is ready to send
    st_d.sck_oe  = act & ((spi & st_q.mst)
                          | (st_q.i2c & ~st_q.mst & st_q.frz & st_d.tde));
    st_d.mosi_oe = act & spi & st_q.mst;
    st_d.miso_oe = act & spi & ~st_q.mst & ~ss_hi;

    // Individual reset: transfer path empties, configuration untouched
    if (!act) begin
      st_d.xs    = scc_pkg::SCC_IDLE;
      st_d.ec    = 6'h00;
      st_d.hfull = 1'b0;
      st_d.tde   = 1'b1;
    end

    if (!rstn_i) begin
      st_d      = '0;
      st_d.cfg  = `SCC_CFG_RESET;
      st_d.tde  = 1'b1;
      st_d.wreq = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    st_q <= st_d;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign avs_readdata_o    = st_q.rdata;
  assign avs_waitrequest_o = st_q.wreq;
  assign sck_o             = st_q.sck;
  assign sck_oe_o          = st_q.sck_oe;
  assign mosi_o            = st_q.tx[23];
  assign mosi_oe_o         = st_q.mosi_oe;
  assign miso_o            = st_q.tx[23];
  assign miso_oe_o         = st_q.miso_oe;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_cfg_reset: assert property (@(posedge sys_clk_i)
    !rstn_i |=> (st_q.cfg == `SCC_CFG_RESET && st_q.tde))
    else $error("reset value of clock config wrong");

  a_stop_keep: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (stop_i && !we_cfg) |=> $stable(st_q.cfg))
    else $error("stop state changed clock config");

  a_off_reset: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    !act |=> (st_q.tde && st_q.xs == scc_pkg::SCC_IDLE && !st_q.hfull))
    else $error("disabled port kept transfer state");

  a_idle_pol: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (st_q.xs == scc_pkg::SCC_IDLE && $past(st_q.xs) == scc_pkg::SCC_IDLE
     && $stable(cpol) && spi && $past(spi) && st_q.mst) |-> st_q.sck == cpol)
    else $error("idle master clock not at polarity level");

  a_tde_clear: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (we_tx && !set_tde && act) |=> !st_q.tde ##1 st_q.hfull || st_q.xs == scc_pkg::SCC_SHIFT)
    else $error("holding write did not clear empty flag");

  a_m1_load: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (load && st_q.mst && cpha) |=> (st_q.tde && st_q.xs == scc_pkg::SCC_SHIFT))
    else $error("master phase 1 load did not set empty flag");

  a_m0_hold: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (load && m0 && !we_tx) |=> (!st_q.tde && st_q.xs == scc_pkg::SCC_SHIFT))
    else $error("master phase 0 set empty flag too early");

  a_s0_ss: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (load && !st_q.mst && !cpha) |-> $past(ss_n_i, 2))
    else $error("slave phase 0 loaded while selected");

  a_rsvd_zero: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (avs_read_i && !avs_waitrequest_o && avs_address_i == `SCC_ADDR_CFG)
    |-> (avs_readdata_o[31:14] == 18'h00000 && !avs_readdata_o[11]))
    else $error("reserved config bits read nonzero");

  a_i2c_quiet: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (st_q.i2c && $past(st_q.i2c)) |-> (!st_q.mosi_oe && !st_q.miso_oe && !st_q.sck))
    else $error("SPI pins driven in two-wire mode");
endmodule

/* scc_partner.sv */
`timescale 1ns/1ps
module scc_partner (
  input  wire logic       cpol_i,
  input  wire logic       cpha_i,
  input  wire logic       slave_en_i,
  input  wire logic [7:0] tx_i,
  input  wire logic       sck_i,
  input  wire logic       mosi_i,
  input  wire logic       miso_i,
  output logic            sck_o,
  output logic            mosi_o,
  output logic            miso_o,
  output logic            ss_n_o,
  output logic [7:0]      rx_o
);
  int   k;
  logic lead;

  initial begin
    sck_o  = 1'b0;
    mosi_o = 1'b0;
    miso_o = 1'b0;
    ss_n_o = 1'b1;
    rx_o   = 8'h00;
    k      = 0;
  end

  // ------------------------------------------------------------
  // Peripheral role: always selected, follows the block's clock
  // ------------------------------------------------------------
  always @(posedge slave_en_i) begin
    rx_o = 8'h00;
    k    = cpha_i ? 7 : 6;
    if (!cpha_i) begin
      miso_o = tx_i[7];
    end
  end

  always @(sck_i) begin
    if (slave_en_i) begin
      lead = (sck_i != cpol_i);
      if (lead ^ cpha_i) begin
        rx_o = {rx_o[6:0], mosi_i};
      end else begin
        // Spent word shows a changing level, never a held one
        miso_o = (k >= 0) ? tx_i[k] : ~miso_o;
        k--;
      end
    end
  end

  // ------------------------------------------------------------
  // Controller role: one 8-bit word, optional short spike first
  // ------------------------------------------------------------
  task automatic master_word(input int half_ns, input bit glitch);
    ss_n_o = 1'b0;
    rx_o   = 8'h00;
    sck_o  = cpol_i;
    k      = cpha_i ? 7 : 6;
    if (!cpha_i) begin
      mosi_o = tx_i[7];
    end
    #(half_ns);
    if (glitch) begin
      // Shorter than the wide tolerance, still longer than one core cycle
      sck_o = ~cpol_i;
      #60;
      sck_o = cpol_i;
      #(half_ns);
    end
    for (int i = 0; i < 16; i++) begin
      sck_o = ~sck_o;
      lead  = (sck_o != cpol_i);
      if (lead ^ cpha_i) begin
        rx_o = {rx_o[6:0], miso_i};
      end else begin
        mosi_o = (k >= 0) ? tx_i[k] : ~mosi_o;
        k--;
      end
      #(half_ns);
    end
    ss_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #(half_ns);
  endtask
endmodule

/* scc_top_test.sv */
`timescale 1ns/1ps
`include "scc_params.svh"
module scc_top_test;
  logic        sys_clk       = 1'b0;
  logic        rstn          = 1'b0;
  logic        stop          = 1'b0;
  logic [3:0]  avs_address   = 4'h0;
  logic        avs_read      = 1'b0;
  logic        avs_write     = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sck_o, sck_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic        p_sck, p_mosi, p_miso, p_ss_n;
  logic [7:0]  p_rx;
  logic        p_cpol        = 1'b0;
  logic        p_cpha        = 1'b0;
  logic        p_slave       = 1'b0;
  logic [7:0]  p_tx          = 8'h00;
  logic [15:0] lfsr_q        = 16'h0035;
  logic [31:0] cfg_m, rd;
  logic        mon_on        = 1'b0;
  logic        sck_prev;
  int          cyc           = 0;
  int          tog_q[$];
  int          n_mismatch    = 0;
  int          cmp_count     = 0;
  wire         sck_w         = (sck_oe === 1'b1) ? sck_o : p_sck;
  wire         mosi_w        = (mosi_oe === 1'b1) ? mosi_o : p_mosi;
  wire         miso_w        = (miso_oe === 1'b1) ? miso_o : p_miso;

  always #20 sys_clk = ~sys_clk;

  scc_top i_scc_top (
    .sys_clk_i         (sys_clk),
    .rstn_i            (rstn),
    .stop_i            (stop),
    .avs_address_i     (avs_address),
    .avs_read_i        (avs_read),
    .avs_write_i       (avs_write),
    .avs_writedata_i   (avs_writedata),
    .avs_readdata_o    (avs_readdata),
    .avs_waitrequest_o (avs_waitrequest),
    .ss_n_i            (p_ss_n),
    .sck_i             (sck_w),
    .sck_o             (sck_o),
    .sck_oe_o          (sck_oe),
    .mosi_i            (mosi_w),
    .mosi_o            (mosi_o),
    .mosi_oe_o         (mosi_oe),
    .miso_i            (miso_w),
    .miso_o            (miso_o),
    .miso_oe_o         (miso_oe)
  );

  scc_partner i_scc_partner (
    .cpol_i     (p_cpol),
    .cpha_i     (p_cpha),
    .slave_en_i (p_slave),
    .tx_i       (p_tx),
    .sck_i      (sck_w),
    .mosi_i     (mosi_w),
    .miso_i     (miso_w),
    .sck_o      (p_sck),
    .mosi_o     (p_mosi),
    .miso_o     (p_miso),
    .ss_n_o     (p_ss_n),
    .rx_o       (p_rx)
  );

  // ------------------------------------------------------------
  // Clock edge log and helpers
  // ------------------------------------------------------------
  always @(posedge sys_clk) begin
    cyc      <= cyc + 1;
    sck_prev <= sck_o;
    if (mon_on && sck_o !== sck_prev) begin
      tog_q.push_back(cyc);
    end
  end

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_write     <= wr;
    avs_read      <= !wr;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 100);
    if (n >= 100) begin
      n_mismatch++;
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  task automatic do_reset();
    rstn <= 1'b0;
    repeat (4) @(posedge sys_clk);
    rstn <= 1'b1;
    cfg_m = 32'h0000_0001;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic master_run(input int i);
    logic [31:0] cfg;
    logic [31:0] data;
    logic [7:0]  m;
    logic        byp;
    int          half;
    int          n;
    // Half period of four or more cycles covers the receive sync delay
    m    = (i < 4) ? 8'(i + 3) : 8'h00;
    byp  = (i < 4);
    cfg  = {21'h0, m, byp, 1'(i / 2), 1'(i % 2)};
    half = (byp ? 1 : 8) * (m + 1);
    wr(`SCC_ADDR_CTL, 32'h0);
    rd_chk("cfg kept", `SCC_ADDR_CFG, cfg_m);
    wr(`SCC_ADDR_CFG, cfg | 32'h00ff_c800);
    cfg_m = cfg;
    rd_chk("cfg masked", `SCC_ADDR_CFG, cfg_m);
    lfsr_q = lfsr_next(lfsr_q);
    p_cpha <= cfg[0];
    p_cpol <= cfg[1];
    p_tx   <= lfsr_q[7:0];
    wr(`SCC_ADDR_CTL, 32'h41);
    repeat (2) @(posedge sys_clk);
    check("sck idle", sck_o, cfg[1]);
    check("mosi oe", mosi_oe, 1'b1);
    tog_q.delete();
    p_slave <= 1'b1;
    mon_on  <= 1'b1;
    lfsr_q = lfsr_next(lfsr_q);
    data   = {8'h0, lfsr_q, lfsr_q[15:8]};
    wr(`SCC_ADDR_DATA, data);
    rd_chk("ctl at load", `SCC_ADDR_CTL, {9'h0, 1'b1, 5'h0, cfg[0], 16'h0041});
    n = 0;
    do begin
      bus(1'b0, `SCC_ADDR_CTL, 32'h0);
      n++;
    end while (rd[22] !== 1'b0 && n < 500);
    check("ctl at end", rd, 32'h0001_0041);
    mon_on <= 1'b0;
    check("sck edges", tog_q.size(), 16);
    for (int j = 1; j < tog_q.size(); j++) begin
      check("half period", tog_q[j] - tog_q[j - 1], half);
    end
    check("sck rest", sck_o, cfg[1]);
    check("peer rx", p_rx, data[23:16]);
    rd_chk("rx word", `SCC_ADDR_DATA, {8'h0, p_tx, 16'h0});
    p_slave <= 1'b0;
  endtask

  task automatic slave_run(input logic cpha);
    logic [31:0] data;
    wr(`SCC_ADDR_CTL, 32'h0);
    // Wide filter with phase 0, narrow filter with phase 1
    cfg_m = {18'h0, 1'b1, ~cpha, 11'h0, cpha};
    wr(`SCC_ADDR_CFG, cfg_m);
    lfsr_q = lfsr_next(lfsr_q);
    p_cpha <= cpha;
    p_cpol <= 1'b0;
    p_tx   <= lfsr_q[15:8];
    // Filters settle before the port comes out of reset
    repeat (25) @(posedge sys_clk);
    wr(`SCC_ADDR_CTL, 32'h1);
    lfsr_q = lfsr_next(lfsr_q);
    data   = {8'h0, lfsr_q, lfsr_q[7:0]};
    wr(`SCC_ADDR_DATA, data);
    repeat (4) @(posedge sys_clk);
    rd_chk("slave ctl", `SCC_ADDR_CTL, 32'h0041_0001);
    i_scc_partner.master_word(600, 1'b1);
    check("peer rx", p_rx, data[23:16]);
    rd_chk("slave rx", `SCC_ADDR_DATA, {8'h0, p_tx, 16'h0});
  endtask

  initial begin
    do_reset();
    rd_chk("cfg reset", `SCC_ADDR_CFG, 32'h0000_0001);
    rd_chk("ctl reset", `SCC_ADDR_CTL, 32'h0001_0000);
    wr(4'hc, 32'hffff_ffff);
    rd_chk("unmapped", 4'hc, 32'h0);
    for (int i = 0; i < 5; i++) begin
      master_run(i);
    end
    stop <= 1'b1;
    repeat (3) @(posedge sys_clk);
    stop <= 1'b0;
    rd_chk("cfg after stop", `SCC_ADDR_CFG, cfg_m);
    slave_run(1'b0);
    slave_run(1'b1);
    wr(`SCC_ADDR_CTL, 32'h0);
    wr(`SCC_ADDR_CFG, 32'h2);
    wr(`SCC_ADDR_CTL, 32'h13);
    repeat (3) @(posedge sys_clk);
    check("freeze oe", sck_oe, 1'b1);
    check("freeze sck", sck_o, 1'b0);
    wr(`SCC_ADDR_CTL, 32'h43);
    repeat (3) @(posedge sys_clk);
    check("two-wire sck", sck_o, 1'b0);
    check("two-wire mosi oe", mosi_oe, 1'b0);
    do_reset();
    rd_chk("cfg re-reset", `SCC_ADDR_CFG, 32'h0000_0001);
    final_report();
  end

  // Whole run needs well under a tenth of this span
  initial begin
    #2_000_000;
    n_mismatch++;
    final_report();
  end
endmodule
